/* File: include/pmrc_defines.svh */
// Constants of the power mode and reset controller: offsets, bit positions, resets, counts.
// Assumes inclusion by bare name from the include folder.
`ifndef PMRC_DEFINES_SVH
`define PMRC_DEFINES_SVH
`define PMRC_RST_QUAL_CLKS 5'd24
`define PMRC_INT_RST_CLKS 12'd2048
`define PMRC_IDLE_BIT 0
`define PMRC_PD_BIT 1
`define PMRC_WDT_KEY_DISABLE 8'h55
`define PMRC_POWER_CONTROL_REG_RESET 8'h00
`define PMRC_WDT_KEY_RESET 8'h00
`define PMRC_ADDR_CTRL 2'h0
`define PMRC_ADDR_POWER_CONTROL_REG 2'h1
`define PMRC_ADDR_KEY 2'h2
`define PMRC_ADDR_STATUS 2'h3
`define PMRC_CTRL_RESET 8'h00
`define PMRC_CTRL_RST_BIT 0
`define PMRC_CTRL_OSC_BIT 1
`define PMRC_CTRL_IRQ_BIT 2
`define PMRC_CTRL_EXT_BIT 3
`define PMRC_CTRL_ADC_BIT 4
`define PMRC_CTRL_DISP_BIT 5
`define PMRC_SYNC_RST 0
`define PMRC_SYNC_OSC 1
`define PMRC_SYNC_IRQ 2
`define PMRC_SYNC_EXT 3
`define PMRC_SYNC_ADC 4
`endif

/* File: include/pmrc_pkg.sv */
// Types shared by both ends of the power mode and reset controller.
// Assumes pmrc_defines.svh holds all numeric constants.
package pmrc_pkg;
	typedef enum logic [1:0] {
		PMRC_RUN,
		PMRC_IDLE,
		PMRC_PDOWN,
		PMRC_WAKE
	} pmrc_state_e;
	typedef logic [7:0] pmrc_byte_t;
endpackage : pmrc_pkg

/* File: include/pmrc_if.sv */
// Link between the power mode and reset controller and its outside party.
// Assumes both ends run on clk_sys; the device end treats the party's reset, oscillator and interrupt lines as pins.
`timescale 1ns/1ps
interface pmrc_if;
	logic reset_pin;
	logic osc_stable;
	logic irq_req;
	logic ext_irq;
	logic adc_cmp_irq;
	logic power_control_reg_wr;
	logic [7:0] power_control_reg_wdata;
	logic wdt_key_wr;
	logic [7:0] wdt_key_wdata;
	logic wdt_start;
	logic [7:0] power_control_reg_rdata;
	logic [7:0] wdt_key_rdata;
	logic wdt_active;
	logic int_rst;
	logic osc_en;
	modport device (
		input reset_pin,
		input osc_stable,
		input irq_req,
		input ext_irq,
		input adc_cmp_irq,
		input power_control_reg_wr,
		input power_control_reg_wdata,
		input wdt_key_wr,
		input wdt_key_wdata,
		input wdt_start,
		output power_control_reg_rdata,
		output wdt_key_rdata,
		output wdt_active,
		output int_rst,
		output osc_en
	);
	modport host (
		output reset_pin,
		output osc_stable,
		output irq_req,
		output ext_irq,
		output adc_cmp_irq,
		output power_control_reg_wr,
		output power_control_reg_wdata,
		output wdt_key_wr,
		output wdt_key_wdata,
		output wdt_start,
		input power_control_reg_rdata,
		input wdt_key_rdata,
		input wdt_active,
		input int_rst,
		input osc_en
	);
endinterface : pmrc_if

/* File: logic/pmrc_host.sv */
// Outside party of the power mode and reset controller: CPU-side orders and reset circuit.
// Assumes a plain register port on clk_sys and the device end on the pmrc_if link.
`timescale 1ns/1ps
`include "pmrc_defines.svh"
module pmrc_host import pmrc_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	pmrc_if.host link,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata_q,
	output logic disp_out_en_q
);
	pmrc_byte_t ctrl_q, ctrl_d;
	logic [7:0] rdata_d;
	logic rst_pin_q, rst_pin_d;
	logic osc_ok_q, osc_ok_d;
	logic [4:0] hold_q, hold_d;
	logic power_control_reg_wr_q, power_control_reg_wr_d;
	pmrc_byte_t power_control_reg_wdata_q, power_control_reg_wdata_d;
	logic key_wr_q, key_wr_d;
	pmrc_byte_t key_wdata_q, key_wdata_d;
	logic start_q, start_d;
	logic refused_q, refused_d;
	logic low_power;
	logic bad_req;

	assign link.reset_pin = rst_pin_q;
	assign link.osc_stable = osc_ok_q;
	assign link.irq_req = ctrl_q[`PMRC_CTRL_IRQ_BIT];
	assign link.ext_irq = ctrl_q[`PMRC_CTRL_EXT_BIT]; // Level, never edge [R13]
	assign link.adc_cmp_irq = ctrl_q[`PMRC_CTRL_ADC_BIT];
	assign link.power_control_reg_wr = power_control_reg_wr_q;
	assign link.power_control_reg_wdata = power_control_reg_wdata_q;
	assign link.wdt_key_wr = key_wr_q;
	assign link.wdt_key_wdata = key_wdata_q; // Full eight-bit key [R16]
	assign link.wdt_start = start_q;
	assign disp_out_en_q = ctrl_q[`PMRC_CTRL_DISP_BIT];

	always_comb begin
		ctrl_d = ctrl_q;
		power_control_reg_wr_d = 1'b0;
		power_control_reg_wdata_d = power_control_reg_wdata_q;
		key_wr_d = 1'b0;
		key_wdata_d = key_wdata_q;
		start_d = 1'b0;
		refused_d = refused_q;
		rdata_d = 8'h00;
		low_power = wdata[`PMRC_IDLE_BIT] | wdata[`PMRC_PD_BIT];
		// Watchdog must be off before idle, display off before any low-power mode
		bad_req = (wdata[`PMRC_IDLE_BIT] & link.wdt_active) // [R5]
			| (low_power & ctrl_q[`PMRC_CTRL_DISP_BIT]); // [R6]
		if (rd && addr == `PMRC_ADDR_STATUS) begin
			refused_d = 1'b0;
		end
		if (wr) begin
			unique case (addr)
				`PMRC_ADDR_CTRL: ctrl_d = wdata;
				`PMRC_ADDR_POWER_CONTROL_REG: begin
					if (bad_req) begin
						refused_d = 1'b1;
					end else begin
						power_control_reg_wr_d = 1'b1;
						power_control_reg_wdata_d = wdata;
					end
				end
				`PMRC_ADDR_KEY: begin
					key_wr_d = 1'b1;
					key_wdata_d = wdata;
				end
				`PMRC_ADDR_STATUS: start_d = 1'b1;
			endcase
		end
		if (rd) begin
			unique case (addr)
				`PMRC_ADDR_CTRL: rdata_d = ctrl_q;
				`PMRC_ADDR_POWER_CONTROL_REG: rdata_d = link.power_control_reg_rdata;
				`PMRC_ADDR_KEY: rdata_d = link.wdt_key_rdata;
				`PMRC_ADDR_STATUS: rdata_d = {4'h0, refused_q, link.wdt_active,
					link.int_rst, link.osc_en};
			endcase
		end
	end

	// Reset line stays up at least the qualifying clocks once the crystal is stable
	always_comb begin
		osc_ok_d = ctrl_q[`PMRC_CTRL_OSC_BIT] & link.osc_en;
		hold_d = 5'd0;
		rst_pin_d = ctrl_q[`PMRC_CTRL_RST_BIT];
		if (rst_pin_q) begin
			hold_d = hold_q;
			if (osc_ok_q && hold_q != `PMRC_RST_QUAL_CLKS) begin
				hold_d = hold_q + 5'd1;
			end
			if (hold_q != `PMRC_RST_QUAL_CLKS) begin
				rst_pin_d = 1'b1; // [R1] [R9]
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_q <= `PMRC_CTRL_RESET;
			rdata_q <= 8'h00;
			rst_pin_q <= 1'b0;
			osc_ok_q <= 1'b0;
			hold_q <= 5'd0;
			power_control_reg_wr_q <= 1'b0;
			power_control_reg_wdata_q <= 8'h00;
			key_wr_q <= 1'b0;
			key_wdata_q <= 8'h00;
			start_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			rst_pin_q <= rst_pin_d;
			osc_ok_q <= osc_ok_d;
			hold_q <= hold_d;
			power_control_reg_wr_q <= power_control_reg_wr_d;
			power_control_reg_wdata_q <= power_control_reg_wdata_d;
			key_wr_q <= key_wr_d;
			key_wdata_q <= key_wdata_d;
			start_q <= start_d;
			refused_q <= refused_d;
		end
	end
endmodule : pmrc_host

/* File: logic/pmrc_device.sv */
// Power mode and reset controller, device end: reset qualification and stretch,
// idle and power-down modes, watchdog key.
// Assumes the party on pmrc_if drives its lines as pins; only the reset, oscillator and interrupt lines are synchronised.
//
// Function
// R1 - Reset qualifies after 24 clocks with stable oscillator
// R2 - Valid reset holds internal reset 2048 clocks
// R3 - Idle bit gates CPU, acquisition, display clocks
// R4 - Idle freezes CPU state, registers, pins
// R5 - Software disables watchdog before requesting idle
// R6 - Software disables display before low-power modes
// R7 - Enabled interrupt clears idle bit, ends idle
// R8 - Analog compare interrupt also wakes from idle
// R9 - Hardware reset ends idle after 24 clocks
// R10 - Reset initialises registers, display memory, restarts
// R11 - Power-down stops oscillator, loses display memory
// R12 - Watchdog disable before power-down only advised
// R13 - Level external interrupt wakes from power-down
// R14 - Analog compare interrupt wakes from power-down
// R15 - Hardware reset ends power-down, full initialisation
// R16 - Active watchdog disabled only by key 55H
// R17 - Wake clears power-down bit, restarts oscillator
`timescale 1ns/1ps
`include "pmrc_defines.svh"
module pmrc_device import pmrc_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	pmrc_if.device link,
	output logic cpu_clk_en_q,
	output logic acq_clk_en_q,
	output logic disp_clk_en_q,
	output logic periph_clk_en_q,
	output logic disp_mem_valid_q,
	output logic pc_restart_q
);
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic pin_rst;
	logic pin_osc;
	logic pin_irq;
	logic pin_ext;
	logic pin_adc;

	logic [4:0] qual_q, qual_d;
	logic [11:0] irst_cnt_q, irst_cnt_d;
	logic int_rst_q, int_rst_d;
	logic rst_valid;

	pmrc_state_e state_q, state_d;
	pmrc_byte_t power_control_reg_q, power_control_reg_d;
	pmrc_byte_t key_q, key_d;
	logic wdt_active_q, wdt_active_d;
	logic osc_en_q, osc_en_d;
	logic cpu_clk_en_d;
	logic acq_clk_en_d;
	logic disp_clk_en_d;
	logic periph_clk_en_d;
	logic disp_mem_valid_d;

	function automatic logic sections_on(input pmrc_state_e st);
		sections_on = (st == PMRC_RUN);
	endfunction : sections_on

	assign pin_rst = sync2_q[`PMRC_SYNC_RST];
	assign pin_osc = sync2_q[`PMRC_SYNC_OSC];
	assign pin_irq = sync2_q[`PMRC_SYNC_IRQ];
	assign pin_ext = sync2_q[`PMRC_SYNC_EXT];
	assign pin_adc = sync2_q[`PMRC_SYNC_ADC];

	assign link.power_control_reg_rdata = power_control_reg_q;
	assign link.wdt_key_rdata = key_q;
	assign link.wdt_active = wdt_active_q;
	assign link.int_rst = int_rst_q;
	assign link.osc_en = osc_en_q;

	// Reset, oscillator and interrupt lines are pins, so each passes two flip-flops first
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
		end else begin
			sync1_q <= {link.adc_cmp_irq, link.ext_irq, link.irq_req,
				link.osc_stable, link.reset_pin};
			sync2_q <= sync1_q;
		end
	end

	// Qualify the reset line, then stretch the internal reset
	always_comb begin
		qual_d = 5'd0;
		rst_valid = 1'b0;
		if (pin_rst && pin_osc) begin
			qual_d = qual_q;
			if (qual_q != `PMRC_RST_QUAL_CLKS) begin
				qual_d = qual_q + 5'd1;
			end
			if (qual_q >= `PMRC_RST_QUAL_CLKS - 5'd1) begin
				rst_valid = 1'b1; // [R1] [R9]
			end
		end
		irst_cnt_d = irst_cnt_q;
		if (rst_valid) begin
			irst_cnt_d = `PMRC_INT_RST_CLKS - 12'd1; // [R2]
		end else if (irst_cnt_q != 12'd0) begin
			irst_cnt_d = irst_cnt_q - 12'd1;
		end
		int_rst_d = rst_valid | (irst_cnt_q != 12'd0); // [R2]
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			qual_q <= 5'd0;
			irst_cnt_q <= 12'd0;
			int_rst_q <= 1'b1;
		end else begin
			qual_q <= qual_d;
			irst_cnt_q <= irst_cnt_d;
			int_rst_q <= int_rst_d;
		end
	end

	// Power modes, power control and watchdog key
	always_comb begin
		state_d = state_q;
		power_control_reg_d = power_control_reg_q;
		key_d = key_q;
		wdt_active_d = wdt_active_q;
		disp_mem_valid_d = disp_mem_valid_q;
		if (int_rst_q) begin
			// Registers and display memory take their initial state [R10] [R15]
			state_d = PMRC_RUN;
			power_control_reg_d = `PMRC_POWER_CONTROL_REG_RESET;
			key_d = `PMRC_WDT_KEY_RESET;
			wdt_active_d = 1'b0;
			disp_mem_valid_d = 1'b1;
		end else begin
			unique case (state_q)
				PMRC_RUN: begin
					if (link.power_control_reg_wr) begin
						power_control_reg_d = link.power_control_reg_wdata;
						// Power-down outranks idle when both are requested
						if (link.power_control_reg_wdata[`PMRC_PD_BIT]) begin
							state_d = PMRC_PDOWN; // [R11]
							disp_mem_valid_d = 1'b0; // [R11]
						end else if (link.power_control_reg_wdata[`PMRC_IDLE_BIT]) begin
							state_d = PMRC_IDLE; // [R3]
						end
					end
				end
				PMRC_IDLE: begin
					// Power control writes are ignored here, the CPU is frozen; watchdog key writes still land [R4]
					if (pin_irq || pin_adc) begin
						power_control_reg_d[`PMRC_IDLE_BIT] = 1'b0; // [R7] [R8]
						state_d = PMRC_RUN; // [R7] [R8]
					end
				end
				PMRC_PDOWN: begin
					// Only level sources can wake, no clock runs to see an edge
					if (pin_ext || pin_adc) begin
						power_control_reg_d[`PMRC_PD_BIT] = 1'b0; // [R13] [R14] [R17]
						state_d = PMRC_WAKE; // [R17]
					end
				end
				PMRC_WAKE: begin
					// CPU waits for the crystal before it takes the interrupt
					if (pin_osc) begin
						state_d = PMRC_RUN; // [R17]
					end
				end
			endcase
			if (link.wdt_key_wr) begin
				key_d = link.wdt_key_wdata;
				if (link.wdt_key_wdata == `PMRC_WDT_KEY_DISABLE) begin
					wdt_active_d = 1'b0; // [R16]
				end
			end
			// Start wins over a key written in the same cycle
			if (link.wdt_start) begin
				wdt_active_d = 1'b1;
			end
		end
	end

	// Clock gates follow the next state so they change with the mode
	always_comb begin
		cpu_clk_en_d = sections_on(state_d); // [R3] [R4]
		acq_clk_en_d = sections_on(state_d); // [R3]
		disp_clk_en_d = sections_on(state_d); // [R3]
		periph_clk_en_d = (state_d == PMRC_RUN) || (state_d == PMRC_IDLE); // [R3]
		// A reset line seen in power-down restarts the crystal for qualification
		osc_en_d = (state_d != PMRC_PDOWN) || pin_rst; // [R11] [R15] [R17]
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= PMRC_RUN;
			power_control_reg_q <= `PMRC_POWER_CONTROL_REG_RESET;
			key_q <= `PMRC_WDT_KEY_RESET;
			wdt_active_q <= 1'b0;
			disp_mem_valid_q <= 1'b0;
			osc_en_q <= 1'b1;
			cpu_clk_en_q <= 1'b1;
			acq_clk_en_q <= 1'b1;
			disp_clk_en_q <= 1'b1;
			periph_clk_en_q <= 1'b1;
			pc_restart_q <= 1'b1;
		end else begin
			state_q <= state_d;
			power_control_reg_q <= power_control_reg_d;
			key_q <= key_d;
			wdt_active_q <= wdt_active_d;
			disp_mem_valid_q <= disp_mem_valid_d;
			osc_en_q <= osc_en_d;
			cpu_clk_en_q <= cpu_clk_en_d;
			acq_clk_en_q <= acq_clk_en_d;
			disp_clk_en_q <= disp_clk_en_d;
			periph_clk_en_q <= periph_clk_en_d;
			pc_restart_q <= int_rst_d; // [R10] [R15]
		end
	end
endmodule : pmrc_device

/* File: test/pmrc_props.sv */
// Checker for the power mode and reset controller link.
// Assumes it sits beside the pmrc_if that joins both ends, on clk_sys.
`timescale 1ns/1ps
module pmrc_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reset_pin,
	input wire logic osc_stable,
	input wire logic irq_req,
	input wire logic ext_irq,
	input wire logic adc_cmp_irq,
	input wire logic power_control_reg_wr,
	input wire logic [7:0] power_control_reg_wdata,
	input wire logic wdt_key_wr,
	input wire logic [7:0] wdt_key_wdata,
	input wire logic wdt_start,
	input wire logic [7:0] power_control_reg_rdata,
	input wire logic wdt_active,
	input wire logic int_rst,
	input wire logic osc_en
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [4:0] qual_q;
	logic [4:0] qual_d;
	logic [11:0] lo_q;
	logic [11:0] lo_d;
	// Saturate so a long reset never wraps into a false short count
	always_comb begin
		qual_d = 5'h00;
		if (reset_pin && osc_stable) begin
			qual_d = (qual_q == 5'h1F) ? qual_q : qual_q + 5'h01;
		end
		lo_d = (lo_q == 12'hFFF) ? lo_q : lo_q + 12'h001;
		if (reset_pin) begin
			lo_d = 12'h000;
		end
	end
	// Start saturated: the stretch after a plain rst is not timed
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			qual_q <= 5'h00;
			lo_q <= 12'hFFF;
		end else begin
			qual_q <= qual_d;
			lo_q <= lo_d;
		end
	end
	sequence s_idle_wake;
		##[1:4] (power_control_reg_rdata == 8'h00);
	endsequence
	sequence s_pd_wake;
		##[1:4] (osc_en && !power_control_reg_rdata[1]);
	endsequence
	a_rst_qual: assert property ($rose(int_rst) |-> qual_q inside {[24:29]})
		else $error("internal reset without a qualified pin");
	a_rst_stretch: assert property ($fell(int_rst) |-> lo_q inside {[2048:2056], 12'hFFF})
		else $error("internal reset stretch wrong");
	a_rst_clears: assert property ($rose(int_rst) |=> power_control_reg_rdata == 8'h00 && !wdt_active)
		else $error("reset left state behind");
	a_mode_enter: assert property (power_control_reg_wr && power_control_reg_wdata inside {8'h01, 8'h02} &&
		power_control_reg_rdata == 8'h00 && !int_rst |=> power_control_reg_rdata == $past(power_control_reg_wdata))
		else $error("mode request not taken");
	a_idle_irq: assert property ($rose(irq_req) && power_control_reg_rdata == 8'h01 |-> s_idle_wake)
		else $error("idle not ended by interrupt");
	a_idle_adc: assert property ($rose(adc_cmp_irq) && power_control_reg_rdata == 8'h01 |-> s_idle_wake)
		else $error("idle not ended by compare");
	a_pd_stop: assert property ($rose(power_control_reg_rdata[1]) |-> ##[0:2] !osc_en)
		else $error("oscillator kept in power-down");
	a_pd_ext: assert property ($rose(ext_irq) && power_control_reg_rdata[1] |-> s_pd_wake)
		else $error("power-down not ended by external");
	a_pd_adc: assert property ($rose(adc_cmp_irq) && power_control_reg_rdata[1] |-> s_pd_wake)
		else $error("power-down not ended by compare");
	a_pd_irq_off: assert property ($rose(irq_req) && power_control_reg_rdata == 8'h02 |->
		##1 (power_control_reg_rdata == 8'h02) [*4])
		else $error("power-down left by plain interrupt");
	a_key_clear: assert property (wdt_key_wr && wdt_key_wdata == 8'h55 && !wdt_start
		|=> !wdt_active)
		else $error("key did not stop watchdog");
	a_key_other: assert property (wdt_active && wdt_key_wr && wdt_key_wdata != 8'h55
		&& !reset_pin |=> wdt_active)
		else $error("wrong key stopped watchdog");
endmodule : pmrc_props

/* File: test/test_power_mode_reset_control.sv */
// Self-checking bench joining both ends of the power mode and reset controller.
// Assumes the host register port is the only stimulus.
`timescale 1ns/1ps
`include "pmrc_defines.svh"
module test_power_mode_reset_control import pmrc_pkg::*;;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic disp_oe, cpu_en, acq_en, dsp_en, per_en, dmv, pcr;
	int n_mismatch = 0;
	int tests_run = 0;
	int n;
	always #4 clk_sys = ~clk_sys;
	pmrc_if lnk ();
	pmrc_host i_pmrc_host (.clk_sys(clk_sys), .rst(rst), .link(lnk.host), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata), .disp_out_en_q(disp_oe));
	pmrc_device i_pmrc_device (.clk_sys(clk_sys), .rst(rst), .link(lnk.device),
		.cpu_clk_en_q(cpu_en), .acq_clk_en_q(acq_en), .disp_clk_en_q(dsp_en),
		.periph_clk_en_q(per_en), .disp_mem_valid_q(dmv), .pc_restart_q(pcr));
	pmrc_props i_pmrc_props (.clk_sys(clk_sys), .rst(rst), .reset_pin(lnk.reset_pin),
		.osc_stable(lnk.osc_stable), .irq_req(lnk.irq_req), .ext_irq(lnk.ext_irq),
		.adc_cmp_irq(lnk.adc_cmp_irq), .power_control_reg_wr(lnk.power_control_reg_wr), .power_control_reg_wdata(lnk.power_control_reg_wdata),
		.wdt_key_wr(lnk.wdt_key_wr), .wdt_key_wdata(lnk.wdt_key_wdata),
		.wdt_start(lnk.wdt_start), .power_control_reg_rdata(lnk.power_control_reg_rdata),
		.wdt_active(lnk.wdt_active), .int_rst(lnk.int_rst), .osc_en(lnk.osc_en));
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	task automatic chk(input pmrc_byte_t g, input pmrc_byte_t e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	// Slack after a write covers host register, pin sync and device update
	task automatic wr_reg(input logic [1:0] a, input pmrc_byte_t d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		repeat (5) @(posedge clk_sys);
		#1;
	endtask : wr_reg
	task automatic rd_chk(input logic [1:0] a, input pmrc_byte_t e);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd_chk
	task automatic wait_rst(input logic lvl);
		for (n = 0; n < 2200 && lnk.int_rst !== lvl; n++)
			#8;
		if (n >= 2200) begin
			n_mismatch++;
			$display("unexpected at %0t: internal reset wait ran out", $time);
			test_done;
		end
	endtask : wait_rst
	task automatic hw_reset;
		wr_reg(2'h0, 8'h03);
		wait_rst(1'b1);
		chk(pcr, 1'b1);
		rd_chk(2'h1, 8'h00);
		rd_chk(2'h2, `PMRC_WDT_KEY_RESET);
		wr_reg(2'h0, 8'h02);
		wait_rst(1'b0);
		chk(n inside {[2040:2056]}, 1'b1);
		#8;
		chk({dmv, cpu_en}, 2'h3);
	endtask : hw_reset
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd_chk(2'h1, `PMRC_POWER_CONTROL_REG_RESET);
		rd_chk(2'h2, `PMRC_WDT_KEY_RESET);
		rd_chk(2'h3, 8'h01);
		// Host stretches any pin pulse, so only a pin without a stable crystal stays unqualified
		wr_reg(2'h0, 8'h01);
		repeat (30) @(posedge clk_sys);
		wr_reg(2'h0, 8'h00);
		rd_chk(2'h3, 8'h01);
		wr_reg(2'h3, 8'h00);
		wr_reg(2'h2, 8'hA5);
		hw_reset;
		rd_chk(2'h3, 8'h01);
		$display("reset test done");
		wr_reg(2'h3, 8'h00);
		wr_reg(2'h1, 8'h01);
		rd_chk(2'h3, 8'h0D);
		wr_reg(2'h2, 8'hAA);
		rd_chk(2'h3, 8'h05);
		rd_chk(2'h2, 8'hAA);
		wr_reg(2'h2, `PMRC_WDT_KEY_DISABLE);
		rd_chk(2'h3, 8'h01);
		wr_reg(2'h0, 8'h22);
		wr_reg(2'h1, 8'h02);
		rd_chk(2'h3, 8'h09);
		wr_reg(2'h0, 8'h02);
		$display("watchdog test done");
		for (int k = 0; k < 2; k++) begin
			wr_reg(2'h1, 8'h01);
			chk({cpu_en, acq_en, dsp_en, per_en, disp_oe}, 5'h02);
			wr_reg(2'h0, k ? 8'h12 : 8'h06);
			chk(cpu_en, 1'b1);
			rd_chk(2'h1, 8'h00);
			wr_reg(2'h0, 8'h02);
		end
		wr_reg(2'h1, 8'h01);
		hw_reset;
		$display("idle test done");
		for (int k = 0; k < 3; k++) begin
			wr_reg(2'h1, 8'h02);
			chk({lnk.osc_en, per_en, dmv, cpu_en}, 4'h0);
			wr_reg(2'h0, k == 0 ? 8'h06 : (k == 1 ? 8'h0A : 8'h12));
			repeat (20) @(posedge clk_sys);
			#1;
			chk({cpu_en, lnk.osc_en}, (k != 0) ? 2'h3 : 2'h0);
			rd_chk(2'h1, k ? 8'h00 : 8'h02);
			wr_reg(2'h0, 8'h02);
		end
		wr_reg(2'h3, 8'h00);
		wr_reg(2'h1, 8'h02);
		rd_chk(2'h3, 8'h04);
		hw_reset;
		$display("power-down test done");
		test_done;
	end
endmodule : test_power_mode_reset_control
